/* hso_defines.svh */
// Purpose: Timing and threshold constants for the hot swap / ORing controller.
// Assumes: 25 MHz clock; all control timing runs on a 1 us tick.
// Notes: Times keep their printed unit; tick counts derive from them.
`ifndef HSO_DEFINES_SVH
`define HSO_DEFINES_SVH
`define HSO_CLK_PERIOD_NS 40
`define HSO_TICK_NS 1000
`define HSO_TICK_CYC ((`HSO_TICK_NS + `HSO_CLK_PERIOD_NS - 1) / `HSO_CLK_PERIOD_NS)
`define HSO_US_TO_TICKS(t) (((t) * 1000 + `HSO_TICK_NS - 1) / `HSO_TICK_NS)
`define HSO_PG_RISE_US 1000
`define HSO_PG_FALL_US 8000
`define HSO_PUMP_DOWN_US 32000
`define HSO_START_WAIT_US 1900
`define HSO_ORING_UP_US 20
`define HSO_ORING_DOWN_US 15
`define HSO_FAST_TRIP_US 63
`define HSO_RETRY_CYCLES 64
`define HSO_TIMER_TERM 1350
`endif

/* hso_pkg.sv */
// Purpose: Types shared by the hot swap / ORing controller.
// Assumes: Comparator results arrive as one packed struct.
// Notes: Each struct bit except the two enable pins is a digitised analog decision.
package hso_pkg;
   typedef struct packed {
      logic swap_en;     // Hot swap enable pin
      logic oring_en;    // ORing enable pin
      logic vds_low;     // Pass FET drain-source below 240 mV
      logic vds_high;    // Pass FET drain-source above 310 mV
      logic mon_high;    // Current monitor level above 101 mV
      logic ac_open;     // Anode-cathode drop above 410 mV
      logic ac_fwd;      // Anode-cathode drop above 10 mV
      logic pump_up;     // Pump node above 5.5 V
      logic pump_low;    // Pump node below 3.7 V
      logic rev;         // Reverse sense pos above reverse sense neg
      logic limiting;    // Inrush regulator in power or current limit
      logic overcurrent; // Sense voltage above current limit
      logic fast_trip;   // Sense voltage above fast trip threshold
      logic overtemp;    // Over-temperature shutdown
   } hso_cmp_s;
   typedef enum logic [1:0] {VAR_LATCH = 2'h0, VAR_RETRY = 2'h1, VAR_FAST = 2'h2} hso_variant_e;
   typedef enum logic [1:0] {OR_PRE = 2'h0, OR_OFF = 2'h1, OR_ON = 2'h2} hso_oring_e;
   typedef enum logic [2:0] {
      SW_WAIT = 3'h0, SW_INRUSH = 3'h1, SW_REG = 3'h2, SW_FAULT = 3'h3,
      SW_LATCHED = 3'h4, SW_RETRY = 3'h5, SW_FTRIP = 3'h6
   } hso_swap_e;
   typedef enum logic [1:0] {
      OG_DN_WEAK = 2'h0, OG_DN_STRONG = 2'h1, OG_UP_STRONG = 2'h2, OG_UP_WEAK = 2'h3
   } hso_ogate_e;
   typedef enum logic [1:0] {HG_OFF = 2'h0, HG_REGULATE = 2'h1, HG_HIGH = 2'h2, HG_FAST = 2'h3} hso_swap_gate_drive_e;
endpackage : hso_pkg

/* hso_ctrl.sv */
// Purpose: ORing and hot swap control state machines with status flags.
// Assumes: Inputs are comparator decisions; one clock, synchronous reset.
// Notes: Timer levels are counters; analog magnitudes appear as drive phases.
// Summary of operation
// [R1] Power-good rises after 1 ms good window
// [R2] Power-good falls after 8 ms bad window
// [R3] Status flag mirrors ORing driver on state
// [R4] Fault on short, timeout, open, overtemp
// [R5] Fault when pump down beyond 32 ms
// [R6] Hot swap waits for pump up first
// [R7] ORing precharge after reset or low pump
// [R8] Precharge to off once pump above 5.5V
// [R9] Off holds gate low; forward drop turns on
// [R10] Strong pull-up 20 us, then weak pull-up
// [R11] Reverse current returns ORing to off
// [R12] Strong pull-down 15 us, then weak pull-down
// [R13] Start-up waits 1.9 ms after pump up
// [R14] Inrush timer runs while limiting; timeout stops
// [R15] Regular keeps timers clear, overcurrent gives fault
// [R16] Fast trip pulses gate down 63 us
// [R17] Fault timer expiry stops; clearing returns regular
// [R18] Latched holds off; enable rise restarts inrush
// [R19] Retry runs 64 timer cycles before restart
// [R20] Timeout when timer exceeds terminal level
// [R21] Variant select and programmable terminal counts
// [R22] Inputs synchronised; times counted in ticks
`include "hso_defines.svh"
module hso_ctrl #(
   parameter int unsigned TICK_CYC = `HSO_TICK_CYC, // Clocks per tick
   parameter int unsigned PG_RISE_TICKS = `HSO_US_TO_TICKS(`HSO_PG_RISE_US), // Good deglitch
   parameter int unsigned PG_FALL_TICKS = `HSO_US_TO_TICKS(`HSO_PG_FALL_US), // Bad deglitch
   parameter int unsigned PUMP_TICKS = `HSO_US_TO_TICKS(`HSO_PUMP_DOWN_US), // Pump down limit
   parameter int unsigned START_TICKS = `HSO_US_TO_TICKS(`HSO_START_WAIT_US), // Start wait
   parameter int unsigned UP_TICKS = `HSO_US_TO_TICKS(`HSO_ORING_UP_US), // Strong pull-up
   parameter int unsigned DOWN_TICKS = `HSO_US_TO_TICKS(`HSO_ORING_DOWN_US), // Strong pull-down
   parameter int unsigned TRIP_TICKS = `HSO_US_TO_TICKS(`HSO_FAST_TRIP_US), // Fast trip pulse
   parameter int unsigned RETRY_CYCLES = `HSO_RETRY_CYCLES, // Retry timer cycles
   parameter int unsigned INR_TERM = `HSO_TIMER_TERM, // Inrush timer terminal level
   parameter int unsigned OC_TERM = `HSO_TIMER_TERM // Fault timer terminal level
) (
   input wire logic mclk_in, // 25 MHz clock
   input wire logic rst_in, // Synchronous reset, active high
   input wire hso_pkg::hso_variant_e variant_sel_in, // Static variant select
   input wire hso_pkg::hso_cmp_s cmp_in, // Comparator and enable inputs
   output logic swap_power_good_out, // Hot swap power good
   output logic oring_status_out, // ORing driver on
   output logic fault_out_n_out, // Fault, active low
   output hso_pkg::hso_ogate_e oring_gate_drive_out, // ORing gate drive phase
   output hso_pkg::hso_swap_gate_drive_e swap_gate_drive_out, // Hot swap gate drive phase
   output hso_pkg::hso_oring_e oring_state_out, // ORing machine state
   output hso_pkg::hso_swap_e swap_state_out // Hot swap machine state
);
   import hso_pkg::*;
   localparam int CW = 16; // Width of tick counters
   localparam int TW = 12; // Width of timer levels
   hso_cmp_s s1_q, c; // Synchroniser stages
   logic en_prev_q; // Enable history for edge detect
   logic [7:0] div_q, div_d; // Tick divider
   logic tick; // One-cycle tick enable
   hso_oring_e og_q, og_d; // ORing state
   logic [CW-1:0] oph_q, oph_d; // ORing strong phase remaining
   hso_ogate_e ogd_q, ogd_d; // ORing drive
   hso_swap_e sw_q, sw_d; // Hot swap state
   logic [CW-1:0] ph_q, ph_d; // Hot swap phase counter
   logic [TW-1:0] inr_q, inr_d; // Inrush timer level
   logic [TW-1:0] oc_q, oc_d; // Fault timer level
   logic [6:0] rty_q, rty_d; // Retry cycle count
   logic rup_q, rup_d; // Retry timer charging
   hso_swap_gate_drive_e hg_q, hg_d; // Hot swap drive
   logic pg_q, pg_d; // Power good
   logic [CW-1:0] pgc_q, pgc_d; // Power-good deglitch count
   logic [CW-1:0] pmp_q, pmp_d; // Pump down duration
   logic flt_q, flt_d; // Fault flag
   logic en_rise, pump_ok, inr_to, oc_to, inr_chg, oc_chg, tmr_clr;

   // Two-flop synchroniser; only the second stage feeds logic
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         s1_q <= '0;
         c <= '0;
         en_prev_q <= 1'b0;
      end else begin
         s1_q <= cmp_in; // R22
         c <= s1_q;
         en_prev_q <= c.swap_en;
      end
   end
   assign en_rise = c.swap_en & ~en_prev_q;

   // Tick divider next value
   always_comb begin
      tick = (div_q == 8'(TICK_CYC - 1)); // R22
      div_d = tick ? 8'h00 : div_q + 8'h01;
   end
   always_ff @(posedge mclk_in) begin
      if (rst_in) div_q <= 8'h00;
      else div_q <= div_d;
   end

   // ORing machine next state
   always_comb begin
      og_d = og_q;
      oph_d = oph_q;
      if (tick && oph_q != '0) oph_d = oph_q - CW'(1); // Strong phase runs down
      case (og_q)
         OR_PRE: begin
            if (c.pump_up) og_d = OR_OFF; // R8
         end
         OR_OFF: begin
            // Only a forward drop with ORing enabled closes the FET
            if (c.oring_en && c.ac_fwd) begin
               og_d = OR_ON; // R9
               oph_d = CW'(UP_TICKS); // R10
            end
         end
         OR_ON: begin
            if (c.rev || !c.oring_en) begin
               og_d = OR_OFF; // R11
               oph_d = CW'(DOWN_TICKS); // R12
            end
         end
         default: og_d = OR_PRE;
      endcase
      // Low pump wins over everything: gate cannot be held up without it
      if (c.pump_low) begin
         og_d = OR_PRE; // R7
         oph_d = '0;
      end
      // Drive follows the next state so output and state line up
      if (og_d == OR_ON) ogd_d = (oph_d != '0) ? OG_UP_STRONG : OG_UP_WEAK; // R10
      else if (og_d == OR_OFF && oph_d != '0) ogd_d = OG_DN_STRONG; // R12
      else ogd_d = OG_DN_WEAK; // R9
   end
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         og_q <= OR_PRE; // R7
         oph_q <= '0;
         ogd_q <= OG_DN_WEAK;
      end else begin
         og_q <= og_d;
         oph_q <= oph_d;
         ogd_q <= ogd_d;
      end
   end
   assign pump_ok = (og_q != OR_PRE);

   // Hot swap machine next state and timers
   always_comb begin
      sw_d = sw_q;
      ph_d = ph_q;
      rty_d = rty_q;
      rup_d = rup_q;
      hg_d = hg_q;
      inr_chg = 1'b0;
      oc_chg = 1'b0;
      tmr_clr = 1'b0;
      inr_to = (inr_q > TW'(INR_TERM)); // R20
      oc_to = (oc_q > TW'(OC_TERM)); // R20
      case (sw_q)
         SW_WAIT: begin
            hg_d = HG_OFF;
            // Count restarts whenever the pump drops or enable goes away
            if (!pump_ok || !c.swap_en) ph_d = '0; // R6
            else if (tick) begin
               if (ph_q >= CW'(START_TICKS - 1)) begin
                  sw_d = SW_INRUSH; // R13
                  hg_d = HG_REGULATE;
                  tmr_clr = 1'b1;
               end else ph_d = ph_q + CW'(1);
            end
         end
         SW_INRUSH: begin
            hg_d = HG_REGULATE;
            inr_chg = c.limiting; // R14
            if (!c.swap_en) begin
               sw_d = SW_WAIT;
               ph_d = '0;
               hg_d = HG_OFF;
            end else if (inr_to) begin
               sw_d = (variant_sel_in == VAR_RETRY) ? SW_RETRY : SW_LATCHED; // R14 R21
               hg_d = HG_OFF;
               rty_d = '0;
               rup_d = 1'b0;
            end else if (!c.limiting && c.vds_low) begin
               sw_d = SW_REG;
               hg_d = HG_HIGH;
            end
         end
         SW_REG, SW_FAULT: begin
            hg_d = HG_HIGH;
            if (sw_q == SW_REG) tmr_clr = 1'b1; // R15
            else oc_chg = c.overcurrent; // R17
            if (!c.swap_en) begin
               sw_d = SW_WAIT;
               ph_d = '0;
               hg_d = HG_OFF;
            end else if (c.fast_trip) begin
               sw_d = SW_FTRIP; // R16
               ph_d = '0;
               hg_d = HG_FAST;
            end else if (sw_q == SW_FAULT && oc_to) begin
               sw_d = (variant_sel_in == VAR_RETRY) ? SW_RETRY : SW_LATCHED; // R17
               hg_d = HG_OFF;
               rty_d = '0;
               rup_d = 1'b0;
            end else if (sw_q == SW_REG && c.overcurrent) sw_d = SW_FAULT; // R15
            else if (sw_q == SW_FAULT && !c.overcurrent) sw_d = SW_REG; // R17
         end
         SW_FTRIP: begin
            hg_d = HG_FAST; // R16
            if (tick) begin
               if (ph_q >= CW'(TRIP_TICKS - 1)) begin
                  tmr_clr = 1'b1;
                  // Fast latch stops until enable rises again; the others try start-up again
                  sw_d = (variant_sel_in == VAR_FAST) ? SW_LATCHED : SW_INRUSH; // R16
                  hg_d = (variant_sel_in == VAR_FAST) ? HG_OFF : HG_REGULATE;
               end else ph_d = ph_q + CW'(1);
            end
         end
         SW_LATCHED: begin
            hg_d = HG_OFF; // R18
            if (en_rise) begin
               sw_d = SW_INRUSH; // R18
               hg_d = HG_REGULATE;
               tmr_clr = 1'b1;
            end
         end
         SW_RETRY: begin
            hg_d = HG_OFF;
            inr_chg = rup_q;
            if (!c.swap_en) begin
               sw_d = SW_WAIT;
               ph_d = '0;
            end else if (rup_q && inr_to) rup_d = 1'b0;
            else if (!rup_q && inr_q == '0) begin
               // One full charge and discharge completed
               if (rty_q == 7'(RETRY_CYCLES - 1)) begin
                  sw_d = SW_INRUSH; // R19
                  hg_d = HG_REGULATE;
               end else begin
                  rty_d = rty_q + 7'h01; // R19
                  rup_d = 1'b1;
               end
            end
         end
         default: sw_d = SW_WAIT;
      endcase
      // Timers charge while their condition holds, else bleed down
      inr_d = inr_q;
      oc_d = oc_q;
      if (tmr_clr) begin
         inr_d = '0; // R15
         oc_d = '0;
      end else if (tick) begin
         if (inr_chg && inr_q != '1) inr_d = inr_q + TW'(1); // R20
         else if (!inr_chg && inr_q != '0) inr_d = inr_q - TW'(1);
         if (oc_chg && oc_q != '1) oc_d = oc_q + TW'(1); // R20
         else if (!oc_chg && oc_q != '0) oc_d = oc_q - TW'(1);
      end
   end
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         sw_q <= SW_WAIT; // R13
         ph_q <= '0;
         inr_q <= '0;
         oc_q <= '0;
         rty_q <= 7'h00;
         rup_q <= 1'b0;
         hg_q <= HG_OFF;
      end else begin
         sw_q <= sw_d;
         ph_q <= ph_d;
         inr_q <= inr_d;
         oc_q <= oc_d;
         rty_q <= rty_d;
         rup_q <= rup_d;
         hg_q <= hg_d;
      end
   end

   // Power-good deglitch, pump watchdog and fault flag
   always_comb begin
      pg_d = pg_q;
      pgc_d = pgc_q;
      pmp_d = pmp_q;
      if (!pg_q) begin
         if (!(c.swap_en && c.vds_low)) pgc_d = '0; // R1
         else if (tick) begin
            if (pgc_q == CW'(PG_RISE_TICKS - 1)) begin
               pg_d = 1'b1; // R1
               pgc_d = '0;
            end else pgc_d = pgc_q + CW'(1);
         end
      end else begin
         if (c.swap_en && !c.vds_high && sw_q != SW_LATCHED) pgc_d = '0; // R2
         else if (tick) begin
            if (pgc_q == CW'(PG_FALL_TICKS - 1)) begin
               pg_d = 1'b0; // R2
               pgc_d = '0;
            end else pgc_d = pgc_q + CW'(1);
         end
      end
      // Saturates one past the limit so a long outage stays flagged
      if (pump_ok) pmp_d = '0;
      else if (tick && pmp_q <= CW'(PUMP_TICKS)) pmp_d = pmp_q + CW'(1); // R5
      flt_d = (!c.swap_en && c.mon_high) // R4
         || sw_q == SW_LATCHED || sw_q == SW_RETRY // R4 R18
         || (c.oring_en && pump_ok && c.ac_open) // R4
         || (pmp_q > CW'(PUMP_TICKS)) // R5
         || c.overtemp; // R4
   end
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         pg_q <= 1'b0;
         pgc_q <= '0;
         pmp_q <= '0;
         flt_q <= 1'b0;
      end else begin
         pg_q <= pg_d;
         pgc_q <= pgc_d;
         pmp_q <= pmp_d;
         flt_q <= flt_d;
      end
   end

   assign swap_power_good_out = pg_q;
   assign oring_status_out = (og_q == OR_ON); // R3
   assign fault_out_n_out = ~flt_q;
   assign oring_gate_drive_out = ogd_q;
   assign swap_gate_drive_out = hg_q;
   assign oring_state_out = og_q;
   assign swap_state_out = sw_q;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   sequence s_trip;
      sw_q == SW_REG && c.swap_en && c.fast_trip;
   endsequence
   sequence s_unlatch;
      sw_q == SW_LATCHED && en_rise;
   endsequence
   AST_PG_RISE: assert property ($rose(pg_q) |-> $past(pgc_q) == CW'(PG_RISE_TICKS - 1)) // R1
      else $error("power good rose early");
   AST_PG_FALL: assert property ($fell(pg_q) |-> $past(pgc_q) == CW'(PG_FALL_TICKS - 1)) // R2
      else $error("power good fell early");
   AST_STATUS: assert property ($rose(oring_status_out) |-> $past(og_q) == OR_OFF) // R3
      else $error("status rose from wrong state");
   AST_LATCH_FAULT: assert property (sw_q == SW_LATCHED |=> !fault_out_n_out) // R4
      else $error("latched without fault");
   AST_PUMP_FAULT: assert property (pmp_q > CW'(PUMP_TICKS) |=> !fault_out_n_out) // R5
      else $error("pump down not reported");
   AST_GATED: assert property ($rose(sw_q == SW_INRUSH) && $past(sw_q) == SW_WAIT |-> $past(pump_ok)) // R6
      else $error("start without pump");
   AST_PRECHARGE: assert property (c.pump_low |=> og_q == OR_PRE) // R7
      else $error("low pump kept ORing active");
   AST_UP_PHASE: assert property (og_q == OR_ON && oph_q != '0 |-> ogd_q == OG_UP_STRONG) // R10
      else $error("strong pull-up missing");
   AST_DN_PHASE: assert property (og_q == OR_OFF && oph_q != '0 |-> ogd_q == OG_DN_STRONG) // R12
      else $error("strong pull-down missing");
   AST_FAST_TRIP: assert property (s_trip |=> sw_q == SW_FTRIP && hg_q == HG_FAST) // R16
      else $error("fast trip not taken");
   AST_REG_CLEAR: assert property (sw_q == SW_REG |=> inr_q == '0 && oc_q == '0) // R15
      else $error("timers not cleared");
   AST_RETRY: assert property ($rose(sw_q == SW_INRUSH) && $past(sw_q) == SW_RETRY
      |-> $past(rty_q) == 7'(RETRY_CYCLES - 1)) // R19
      else $error("retry count wrong");
   AST_UNLATCH: assert property (s_unlatch |=> sw_q == SW_INRUSH && inr_q == '0 && oc_q == '0) // R18
      else $error("enable edge did not restart");
endmodule // hso_ctrl

/* hso_plant.sv */
// Purpose: Behavioural model of the pump node, pass FET and load.
// Assumes: Gate phases come from the controller; knobs come from the bench.
// Notes: Decisions are levels; the controller synchronises them itself.
module hso_plant
   import hso_pkg::*;
(
   input wire logic mclk_in, // Clock
   input wire logic pump_on_in, // Bench lets the pump node charge
   input wire logic heavy_in, // Load holds the regulator in limit
   input wire hso_pkg::hso_swap_gate_drive_e gate_in, // Pass FET gate phase
   output logic pump_up_out, // Pump above upper threshold
   output logic pump_low_out, // Pump below lower threshold
   output logic vds_low_out, // Pass FET fully enhanced
   output logic vds_high_out, // Pass FET off or stressed
   output logic limiting_out // Regulator in power or current limit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] lvl_q; // Pump charge level
   // Pump charges over several cycles but collapses at once when stopped
   always_ff @(posedge mclk_in) begin
      if (!pump_on_in) begin
         lvl_q <= 3'h0;
      end else if (lvl_q != 3'h7) begin
         lvl_q <= lvl_q + 3'h1;
      end
   end
   // Between the thresholds neither flag is set, like a real slow node
   assign pump_up_out = (lvl_q == 3'h7);
   assign pump_low_out = (lvl_q < 3'h3);
   // Only a gate driven up collapses the drop; a heavy load keeps it high
   assign vds_low_out = (gate_in != HG_OFF) && (gate_in != HG_FAST) && !heavy_in;
   assign vds_high_out = !vds_low_out;
   assign limiting_out = heavy_in && (gate_in == HG_REGULATE);
endmodule // hso_plant

/* hot_swap_oring_control_fsm_test.sv */
// Purpose: Self-checking bench for the hot swap / ORing controller.
// Assumes: Shortened tick and count parameters; inputs change on falling edges.
// Notes: Waits are bounded; a hang ends in the closing report.
module hot_swap_oring_control_fsm_test;
   timeunit 1ns;
   timeprecision 1ps;
   import hso_pkg::*;
   localparam int P_SW = 0; // Probe selectors
   localparam int P_OR = 1;
   localparam int P_OG = 2;
   localparam int P_HG = 3;
   localparam int P_FL = 4;
   logic mclk_in = 1'b0; // Clock
   logic rst = 1'b1; // Reset
   logic pump_on = 1'b0; // Plant knob
   logic heavy = 1'b0; // Plant knob
   hso_variant_e variant = VAR_LATCH; // Variant select
   hso_cmp_s drv = '0; // Bench-driven decisions
   hso_cmp_s cmp; // Combined decisions
   logic p_up, p_low, v_low, v_high, lim; // Plant decisions
   logic pg, stat, flt_n; // Flags
   hso_ogate_e og; // ORing drive
   hso_swap_gate_drive_e hg; // Swap drive
   hso_oring_e ost; // ORing state
   hso_swap_e sst; // Swap state
   int err_total = 0; // Mismatches
   int checked = 0; // Comparisons
   int cycles = 0; // Watchdog
   initial begin
      forever #20 mclk_in = ~mclk_in;
   end
   // Plant owns the electrical decisions, the bench the rest
   always_comb begin
      cmp = drv;
      cmp.pump_up = p_up;
      cmp.pump_low = p_low;
      cmp.vds_low = v_low;
      cmp.vds_high = v_high;
      cmp.limiting = lim;
   end
   hso_plant plant (.mclk_in(mclk_in), .pump_on_in(pump_on), .heavy_in(heavy), .gate_in(hg),
      .pump_up_out(p_up), .pump_low_out(p_low), .vds_low_out(v_low), .vds_high_out(v_high),
      .limiting_out(lim));
   // Tick, pump, start and power-good fall waits and inrush terminal are shortened; power-good rise, drive phases, retry count and fault timer keep their real counts
   hso_ctrl #(.TICK_CYC(2), .PG_FALL_TICKS(8), .PUMP_TICKS(20), .START_TICKS(5), .INR_TERM(6)) DUT (
      .mclk_in(mclk_in), .rst_in(rst), .variant_sel_in(variant), .cmp_in(cmp),
      .swap_power_good_out(pg), .oring_status_out(stat), .fault_out_n_out(flt_n),
      .oring_gate_drive_out(og), .swap_gate_drive_out(hg), .oring_state_out(ost), .swap_state_out(sst));
   // Watchdog: the whole run needs well under this many cycles
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Flags packed as {pg, fault_n} so one probe covers both
   function automatic logic [3:0] probe(input int sel);
      case (sel)
         P_SW: return 4'(sst);
         P_OR: return 4'(ost);
         P_OG: return 4'(og);
         P_HG: return 4'(hg);
         default: return {2'h0, pg, flt_n};
      endcase
   endfunction
   task automatic await(input string what, input int sel, input logic [3:0] v, input int lim_c);
      int n;
      n = 0;
      while (probe(sel) !== v && n < lim_c) begin
         @(negedge mclk_in);
         n++;
      end
      check(what, v, probe(sel));
   endtask
   task automatic hold(input int n);
      repeat (n) @(negedge mclk_in);
   endtask
   // Reset clears inputs together so the synchronisers flush too
   task automatic do_reset(input hso_variant_e v);
      @(negedge mclk_in);
      variant = v;
      drv = '0;
      pump_on = 1'b0;
      heavy = 1'b0;
      rst = 1'b1;
      hold(2);
      rst = 1'b0;
      check("reset oring", OR_PRE, probe(P_OR));
      check("reset flags", 4'h1, probe(P_FL));
   endtask
   // Start-up: pump gates the hot swap, then the start wait runs
   task automatic start_up();
      drv.swap_en = 1'b1;
      hold(40);
      check("no start without pump", SW_WAIT, probe(P_SW));
      pump_on = 1'b1;
      await("pump up", P_OR, OR_OFF, 14);
      hold(6);
      check("start wait", SW_WAIT, probe(P_SW));
      await("inrush", P_SW, SW_INRUSH, 10);
      await("regular", P_SW, SW_REG, 10);
      check("gate high", HG_HIGH, probe(P_HG));
      check("pg early", 4'h1, probe(P_FL));
      await("pg rise", P_FL, 4'h3, 2010);
   endtask
   task automatic s_oring();
      drv.oring_en = 1'b1;
      drv.ac_fwd = 1'b1;
      await("oring on", P_OR, OR_ON, 8);
      check("status on", 4'h1, {3'h0, stat});
      hold(3);
      check("strong up", OG_UP_STRONG, probe(P_OG));
      await("weak up", P_OG, OG_UP_WEAK, 50);
      drv.ac_fwd = 1'b0;
      drv.rev = 1'b1;
      await("oring off", P_OR, OR_OFF, 8);
      check("status off", 4'h0, {3'h0, stat});
      check("strong down", OG_DN_STRONG, probe(P_OG));
      await("weak down", P_OG, OG_DN_WEAK, 40);
      drv.rev = 1'b0;
   endtask
   // Short overcurrent returns to regular; a long one latches off
   task automatic s_overcurrent();
      drv.overcurrent = 1'b1;
      await("fault mode", P_SW, SW_FAULT, 6);
      hold(4);
      drv.overcurrent = 1'b0;
      await("recover", P_SW, SW_REG, 6);
      hold(20);
      drv.overcurrent = 1'b1;
      await("timer latch", P_SW, SW_LATCHED, 2800);
      await("latched fault", P_FL, 4'h2, 4);
      check("latched gate", HG_OFF, probe(P_HG));
      await("pg fall", P_FL, 4'h0, 24);
      drv.overcurrent = 1'b0;
      drv.swap_en = 1'b0;
      hold(6);
      check("stays latched", SW_LATCHED, probe(P_SW));
      drv.swap_en = 1'b1;
      await("enable restart", P_SW, SW_INRUSH, 8);
   endtask
   // Fast trip response for one variant
   task automatic s_fast(input hso_variant_e v);
      do_reset(v);
      start_up();
      drv.fast_trip = 1'b1;
      await("fast trip", P_SW, SW_FTRIP, 6);
      check("trip gate", HG_FAST, probe(P_HG));
      drv.fast_trip = 1'b0;
      hold(4);
      check("trip pulse", SW_FTRIP, probe(P_SW));
      await("after trip", P_SW, (v == VAR_FAST) ? SW_LATCHED : SW_INRUSH, 140);
   endtask
   // Inrush timeout in the retry variant, then 64 timer cycles
   task automatic s_retry();
      do_reset(VAR_RETRY);
      heavy = 1'b1;
      drv.swap_en = 1'b1;
      pump_on = 1'b1;
      await("limit inrush", P_SW, SW_INRUSH, 40);
      check("regulating", HG_REGULATE, probe(P_HG));
      await("retry", P_SW, SW_RETRY, 24);
      heavy = 1'b0;
      await("retry fault", P_FL, 4'h0, 4);
      hold(1400);
      check("retry count", SW_RETRY, probe(P_SW));
      await("retry start", P_SW, SW_INRUSH, 600);
   endtask
   // Fault sources: pump down, overtemp, short, open ORing FET
   task automatic s_faults();
      do_reset(VAR_LATCH);
      hold(30);
      check("pump short down", 4'h1, probe(P_FL));
      await("pump long down", P_FL, 4'h0, 20);
      pump_on = 1'b1;
      await("pump back", P_FL, 4'h1, 20);
      drv.overtemp = 1'b1;
      await("overtemp", P_FL, 4'h0, 5);
      drv.overtemp = 1'b0;
      await("overtemp clear", P_FL, 4'h1, 5);
      drv.mon_high = 1'b1;
      await("shorted fet", P_FL, 4'h0, 5);
      drv.mon_high = 1'b0;
      await("short clear", P_FL, 4'h1, 5);
      drv.oring_en = 1'b1;
      drv.ac_open = 1'b1;
      await("open fet", P_FL, 4'h0, 5);
      pump_on = 1'b0;
      await("pump lost", P_OR, OR_PRE, 6);
   endtask
   initial begin
      hold(2);
      rst = 1'b0;
      do_reset(VAR_LATCH);
      start_up();
      s_oring();
      s_overcurrent();
      s_fast(VAR_LATCH);
      s_fast(VAR_RETRY);
      s_fast(VAR_FAST);
      s_retry();
      s_faults();
      close_out();
   end
endmodule // hot_swap_oring_control_fsm_test
